// *** logic/sepg_pkg.sv ***
package sepg_pkg;
	localparam int ADDR_W = 7;
	localparam int MEM_DEPTH = 128;
	localparam int ROW_W = 3;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	// type code; arbitrary value
	localparam logic [3:0] TYPE_CODE = 4'h5;
	localparam int CLK_MHZ = 50;
	localparam int PROG_TIME_US = 10000;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int LINK_DIV = 4;
	localparam logic [2:0] CMD_IDLE = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h1;
	localparam logic [2:0] CMD_CUR_READ = 3'h2;
	localparam logic [2:0] CMD_RAND_READ = 3'h3;
	localparam logic [2:0] CMD_POLL = 3'h4;
endpackage

// *** logic/sepg_if.sv ***
`timescale 1ns/10ps
interface sepg_if;
	logic scl;
	logic sda_host_out;
	logic sda_host_oe_n;
	logic sda_dev_out;
	logic sda_dev_oe_n;
	wire sda = ~((~sda_host_oe_n & ~sda_host_out) | (~sda_dev_oe_n & ~sda_dev_out));
	modport device (input scl, input sda, output sda_dev_out, output sda_dev_oe_n);
	modport host (output scl, input sda, output sda_host_out, output sda_host_oe_n);
endinterface

// *** logic/sepg_device.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - page write of one to eight bytes
// - ack data, advance low three address bits
// - master keeps page within remaining row; host does not check this, device wraps within the row
// - stop after data starts programming
// - bus ignored while programming runs
// - busy: no select ack; then ack
// - master polls select until acknowledged
// - reads ignore write mode pin
// - memory starts all ones
// - current read sends counter byte, increments
// - master ends read with nack, stop
// - dummy write loads address, then read
// - master ack gives next byte
// - read counter wraps to zero
// - nack on ninth clock ends read
// - select: type, straps, direction bit
// - start, seven bits, direction, ack
// - start/stop detect, idle until start
// - seven-bit address, top bit ignored
// - protect high blocks data acks, writes
module sepg_device #(
	parameter int PROG_COUNT = sepg_pkg::PROG_CYCLES
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// bus
	sepg_if.device bus,
	// straps
	input wire logic [2:0] chip_select_straps_in,
	input wire logic write_protect_input_in,
	input wire logic page_mode_n_in,
	// status
	output logic busy_out
);
	if (PROG_COUNT < 1) begin
		$error("PROG_COUNT must be at least 1");
	end

	typedef enum logic [4:0] {
		SEPG_IDLE = 5'h01, SEPG_RX = 5'h02, SEPG_ACK = 5'h04, SEPG_TX = 5'h08, SEPG_RACK = 5'h10
	} sepg_state_t;

	logic [2:0] scl_s, sda_s;
	// strap and protect pins come from outside the clock domain
	logic [2:0] strap_s1, strap_s2;
	logic [1:0] wp_s;
	logic [7:0] mem [sepg_pkg::MEM_DEPTH];
	logic [7:0] row [8];
	logic [7:0] row_used;
	logic [sepg_pkg::ADDR_W-4:0] row_base;
	sepg_state_t state;
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic [1:0] phase;
	logic [sepg_pkg::ADDR_W-1:0] addr;
	logic protect, sda_drive, pending;
	logic [31:0] prog_cnt;

	wire scl_rise = scl_s[1] & ~scl_s[2];
	wire scl_fall = ~scl_s[1] & scl_s[2];
	wire start_det = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
	wire stop_det = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
	wire [7:0] rx_byte = {shreg[6:0], sda_s[1]};
	// shreg already holds the whole select byte at the fall after bit 8
	wire sel_match = shreg[7:4] == sepg_pkg::TYPE_CODE && shreg[3:1] == strap_s2;
	wire [2:0] row_lo = addr[2:0];
	wire [sepg_pkg::ADDR_W-1:0] addr_inc = addr + 7'h01;

	assign bus.sda_dev_out = 1'b0;
	assign bus.sda_dev_oe_n = ~sda_drive;
	assign busy_out = prog_cnt != 32'h0;

	////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
			wp_s <= 2'h0;
		end else begin
			scl_s <= {scl_s[1:0], bus.scl};
			sda_s <= {sda_s[1:0], bus.sda};
			strap_s1 <= chip_select_straps_in;
			strap_s2 <= strap_s1;
			wp_s <= {wp_s[0], write_protect_input_in};
		end
	end

	////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < sepg_pkg::MEM_DEPTH; i++) begin
				mem[i] <= sepg_pkg::ERASED_BYTE;
			end
			for (int i = 0; i < 8; i++) begin
				row[i] <= 8'h00;
			end
			row_used <= 8'h00;
			row_base <= '0;
			state <= SEPG_IDLE;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			phase <= 2'h0;
			addr <= '0;
			protect <= 1'b0;
			sda_drive <= 1'b0;
			pending <= 1'b0;
			prog_cnt <= 32'h0;
		end else if (prog_cnt != 32'h0) begin
			// bus ignored until done
			prog_cnt <= prog_cnt - 32'h1;
			state <= SEPG_IDLE;
			sda_drive <= 1'b0;
			if (prog_cnt == 32'h1) begin
				for (int i = 0; i < 8; i++) begin
					if (row_used[i]) begin
						mem[{row_base, 3'(i)}] <= row[i];
					end
				end
				row_used <= 8'h00;
			end
		end else if (stop_det) begin
			state <= SEPG_IDLE;
			sda_drive <= 1'b0;
			if (pending && row_used != 8'h00) begin
				prog_cnt <= 32'(PROG_COUNT);
			end
			pending <= 1'b0;
		end else if (start_det) begin
			state <= SEPG_RX;
			bitcnt <= 4'h0;
			phase <= 2'h0;
			sda_drive <= 1'b0;
			protect <= wp_s[1];
			row_used <= 8'h00;
			pending <= 1'b0;
		end else begin
			if (wp_s[1] && phase != 2'h2 && state != SEPG_IDLE) begin
				protect <= 1'b1;
			end
			unique case (state)
				SEPG_IDLE: begin
				end
				SEPG_RX: begin
					if (scl_rise) begin
						shreg <= rx_byte;
						bitcnt <= bitcnt + 4'h1;
					end
					if (scl_fall && bitcnt == 4'h8) begin
						state <= SEPG_ACK;
						if (phase == 2'h0) begin
							if (!sel_match) begin
								state <= SEPG_IDLE;
							end
						end else if (phase == 2'h1) begin
							addr <= shreg[sepg_pkg::ADDR_W-1:0];
							row_base <= shreg[sepg_pkg::ADDR_W-1:3];
						end else if (!protect) begin
							row[row_lo] <= shreg;
							row_used[row_lo] <= 1'b1;
							addr <= {addr[sepg_pkg::ADDR_W-1:3], row_lo + 3'h1};
							pending <= 1'b1;
						end
						sda_drive <= phase != 2'h2 ? sel_match | (phase == 2'h1) : ~protect;
					end
				end
				SEPG_ACK: begin
					if (scl_fall) begin
						sda_drive <= 1'b0;
						bitcnt <= 4'h0;
						if (phase == 2'h0 && shreg[0]) begin
							state <= SEPG_TX;
							shreg <= mem[addr];
							sda_drive <= ~mem[addr][7];
							bitcnt <= 4'h1;
							addr <= addr_inc;
						end else begin
							state <= SEPG_RX;
							if (phase != 2'h2) begin
								phase <= phase + 2'h1;
							end
						end
					end
				end
				SEPG_TX: begin
					if (scl_fall) begin
						if (bitcnt == 4'h8) begin
							state <= SEPG_RACK;
							sda_drive <= 1'b0;
						end else begin
							sda_drive <= ~shreg[3'(7 - bitcnt)];
							bitcnt <= bitcnt + 4'h1;
						end
					end
				end
				SEPG_RACK: begin
					// master ack marks bitcnt; next byte goes out at the following fall
					if (scl_rise && sda_s[1]) begin
						state <= SEPG_IDLE;
					end
					if (scl_rise && !sda_s[1]) begin
						bitcnt <= 4'h9;
					end
					if (scl_fall && bitcnt == 4'h9) begin
						state <= SEPG_TX;
						shreg <= mem[addr];
						sda_drive <= ~mem[addr][7];
						bitcnt <= 4'h1;
						addr <= addr_inc;
					end
				end
				default: state <= SEPG_IDLE;
			endcase
		end
	end
endmodule

// *** logic/sepg_host.sv ***
`timescale 1ns/10ps
module sepg_host #(
	parameter int DIV = sepg_pkg::LINK_DIV
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// bus
	sepg_if.host bus,
	// command
	input wire logic [2:0] cmd_in,
	input wire logic cmd_valid_in,
	input wire logic [2:0] dev_sel_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic [3:0] count_in,
	// status
	output logic ready_out,
	output logic acked_out,
	output logic [7:0] rdata_out,
	output logic rdata_valid_out
);
	if (DIV < 2 || DIV > 256) begin
		$error("DIV must be 2 to 256");
	end

	typedef enum logic [3:0] {
		SEPG_H_IDLE = 4'h1, SEPG_H_START = 4'h2, SEPG_H_BIT = 4'h4, SEPG_H_STOP = 4'h8
	} sepg_hstate_t;

	sepg_hstate_t state;
	logic [1:0] sda_s;
	logic [7:0] div_cnt;
	logic [1:0] quarter;
	logic [8:0] sh;
	logic [3:0] bitn;
	logic [3:0] bytes_left;
	logic [2:0] cmd;
	logic [1:0] stage;
	logic [7:0] rx;

	wire tick = div_cnt == 8'(DIV - 1);
	// stage 2 is the read select of a random read, stage 3 a data byte
	wire is_read = cmd == sepg_pkg::CMD_CUR_READ || (cmd == sepg_pkg::CMD_RAND_READ && stage[1]);
	wire rx_data = is_read && stage == 2'h3;

	assign ready_out = state == SEPG_H_IDLE;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sda_s <= 2'h3;
		end else begin
			sda_s <= {sda_s[0], bus.sda};
		end
	end

	// quarter-phase bit engine; sends 9 bits per byte (ack/nack last)
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= SEPG_H_IDLE;
			bus.scl <= 1'b1;
			bus.sda_host_out <= 1'b0;
			bus.sda_host_oe_n <= 1'b1;
			div_cnt <= 8'h00;
			quarter <= 2'h0;
			sh <= 9'h000;
			bitn <= 4'h0;
			bytes_left <= 4'h0;
			cmd <= sepg_pkg::CMD_IDLE;
			stage <= 2'h0;
			rx <= 8'h00;
			acked_out <= 1'b0;
			rdata_out <= 8'h00;
			rdata_valid_out <= 1'b0;
		end else begin
			rdata_valid_out <= 1'b0;
			div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
			unique case (state)
				SEPG_H_IDLE: begin
					if (cmd_valid_in) begin
						cmd <= cmd_in;
						stage <= 2'h0;
						bytes_left <= count_in;
						state <= SEPG_H_START;
						quarter <= 2'h0;
					end
				end
				SEPG_H_START: if (tick) begin
					quarter <= quarter + 2'h1;
					if (quarter == 2'h0) begin
						bus.scl <= 1'b1;
						bus.sda_host_oe_n <= 1'b1;
					end else if (quarter == 2'h1) begin
						bus.sda_host_oe_n <= 1'b0; // start: sda low while scl high
					end else if (quarter == 2'h2) begin
						bus.scl <= 1'b0;
						sh <= {sepg_pkg::TYPE_CODE, dev_sel_in,
							cmd == sepg_pkg::CMD_CUR_READ || stage == 2'h2, 1'b1};
						bitn <= 4'h0;
						quarter <= 2'h0;
						state <= SEPG_H_BIT;
					end
				end
				SEPG_H_BIT: if (tick) begin
					quarter <= quarter + 2'h1;
					if (quarter == 2'h0) begin
						bus.sda_host_oe_n <= sh[8];
					end else if (quarter == 2'h1) begin
						bus.scl <= 1'b1;
					end else if (quarter == 2'h2) begin
						if (bitn < 4'h8) begin
							rx <= {rx[6:0], sda_s[1]};
						end else begin
							acked_out <= ~sda_s[1];
						end
					end else begin
						bus.scl <= 1'b0;
						sh <= {sh[7:0], 1'b1};
						bitn <= bitn + 4'h1;
						if (bitn == 4'h8) begin
							bitn <= 4'h0;
							if (rx_data) begin
								rdata_out <= rx;
								rdata_valid_out <= 1'b1;
							end
							// on read data bytes the ninth bit is our own ack, not the device's
							if (sda_s[1] && !rx_data) begin
								state <= SEPG_H_STOP;
							end else if (cmd == sepg_pkg::CMD_POLL || bytes_left == 4'h0) begin
								state <= SEPG_H_STOP;
							end else if (cmd == sepg_pkg::CMD_RAND_READ && stage == 2'h1) begin
								stage <= 2'h2;
								state <= SEPG_H_START;
							end else begin
								stage <= stage == 2'h0 ? 2'h1 : stage;
								if (is_read) begin
									stage <= 2'h3;
									bytes_left <= bytes_left - 4'h1;
									sh <= {8'hff, bytes_left == 4'h1};
								end else if (stage == 2'h0) begin
									sh <= {addr_in, 1'b1};
								end else begin
									bytes_left <= bytes_left - 4'h1;
									sh <= {wdata_in, 1'b1};
								end
							end
						end
					end
				end
				SEPG_H_STOP: if (tick) begin
					quarter <= quarter + 2'h1;
					if (quarter == 2'h0) begin
						bus.sda_host_oe_n <= 1'b0;
					end else if (quarter == 2'h1) begin
						bus.scl <= 1'b1;
					end else if (quarter == 2'h2) begin
						bus.sda_host_oe_n <= 1'b1;
						state <= SEPG_H_IDLE;
						quarter <= 2'h0;
					end
				end
				default: state <= SEPG_H_IDLE;
			endcase
		end
	end
endmodule

// *** dv/sepg_assertions.sv ***
`timescale 1ns/10ps
module sepg_assertions #(
	parameter int PROG_COUNT = 400
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// link
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_dev_oe_n_in,
	input wire logic sda_host_oe_n_in,
	// status
	input wire logic busy_in
);
	logic [31:0] busy_len;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_len <= 32'h0;
		end else begin
			busy_len <= busy_in ? busy_len + 32'h1 : 32'h0;
		end
	end
	////////////////////////////////////////////////////////////////
	chk_no_collision: assert property (!sda_dev_oe_n_in && scl_in |-> sda_host_oe_n_in)
		else $error("device and host drive sda together");
	chk_busy_silent: assert property (busy_in |-> sda_dev_oe_n_in)
		else $error("device drives sda while programming");
	chk_drive_scl_low: assert property ($changed(sda_dev_oe_n_in) |-> !scl_in)
		else $error("device sda changed while scl high");
	chk_drive_holds: assert property ($fell(sda_dev_oe_n_in) |-> !sda_dev_oe_n_in [*8])
		else $error("device drive shorter than a bit");
	chk_start_free: assert property (($fell(sda_in) && scl_in && $past(scl_in)) |-> sda_dev_oe_n_in)
		else $error("device drives sda at start");
	chk_stop_free: assert property (($rose(sda_in) && scl_in && $past(scl_in)) |=> sda_dev_oe_n_in [*8])
		else $error("device drives sda after stop");
	chk_busy_at_stop: assert property ($rose(busy_in) |-> scl_in && sda_in)
		else $error("programming began outside stop");
	chk_program_time: assert property ($fell(busy_in) |-> busy_len >= PROG_COUNT - 3 && busy_len <= PROG_COUNT + 3)
		else $error("programming time wrong");
	chk_busy_bound: assert property (busy_len <= PROG_COUNT + 3)
		else $error("programming never ends");
	cover property ($rose(busy_in));
	cover property ($fell(busy_in));
	cover property ($fell(sda_dev_oe_n_in));
	cover property ($fell(sda_in) && scl_in);
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	localparam int PROG = 400;
	localparam logic [2:0] STRAP = 3'h5;
	localparam logic [63:0] ROW_EXP = 64'ha5a5_ffff_ffff_a5a5;
	logic clk_in;
	logic arst_n_in;
	logic [2:0] cmd_in;
	logic cmd_valid_in;
	logic [2:0] dev_sel_in;
	logic [7:0] addr_in;
	logic [7:0] wdata_in;
	logic [3:0] count_in;
	logic write_protect_input;
	logic page_mode_n;
	logic busy_out;
	logic ready_out;
	logic acked_out;
	logic [7:0] rdata_out;
	logic rdata_valid_out;
	logic [7:0] rq[$];
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	sepg_if bus_if();
	sepg_device #(.PROG_COUNT(PROG)) sepg_device_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus(bus_if.device),
		.chip_select_straps_in(STRAP), .write_protect_input_in(write_protect_input),
		.page_mode_n_in(page_mode_n), .busy_out(busy_out));
	sepg_host sepg_host_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus(bus_if.host), .cmd_in(cmd_in),
		.cmd_valid_in(cmd_valid_in), .dev_sel_in(dev_sel_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.count_in(count_in), .ready_out(ready_out), .acked_out(acked_out), .rdata_out(rdata_out),
		.rdata_valid_out(rdata_valid_out));
	sepg_assertions #(.PROG_COUNT(PROG)) sepg_assertions_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.scl_in(bus_if.scl), .sda_in(bus_if.sda), .sda_dev_oe_n_in(bus_if.sda_dev_oe_n),
		.sda_host_oe_n_in(bus_if.sda_host_oe_n), .busy_in(busy_out));
	////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	always @(negedge clk_in) begin
		if (rdata_valid_out === 1'b1) begin
			rq.push_back(rdata_out);
		end
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 80000) begin
			n_fail++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_rdy();
		int k;
		k = 0;
		@(negedge clk_in);
		while (ready_out !== 1'b1 && k < 9000) begin
			@(negedge clk_in);
			k++;
		end
		if (ready_out !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
	endtask
	task automatic run(input logic [2:0] c, input logic [2:0] s, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] n);
		wait_rdy();
		rq.delete();
		@(posedge clk_in);
		cmd_in <= c;
		dev_sel_in <= s;
		addr_in <= a;
		wdata_in <= d;
		count_in <= n;
		cmd_valid_in <= 1'b1;
		@(posedge clk_in);
		cmd_valid_in <= 1'b0;
		wait_rdy();
	endtask
	task automatic poll_wait();
		int p;
		p = 0;
		do begin
			run(sepg_pkg::CMD_POLL, STRAP, 8'h00, 8'h00, 4'h0);
			p++;
		end while (acked_out !== 1'b1 && p < 30);
		check("poll ack", acked_out, 8'h01);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		arst_n_in = 1'b0;
		cmd_in = 3'h0;
		cmd_valid_in = 1'b0;
		dev_sel_in = STRAP;
		addr_in = 8'h00;
		wdata_in = 8'h00;
		count_in = 4'h0;
		write_protect_input = 1'b0;
		page_mode_n = 1'b0;
		repeat (5) @(posedge clk_in);
		arst_n_in <= 1'b1;
		run(sepg_pkg::CMD_RAND_READ, STRAP, 8'h10, 8'h00, 4'h1);
		check("erased", rq[0], sepg_pkg::ERASED_BYTE);
		$display("test erased done");
		// page starting two bytes before row end wraps inside the row
		run(sepg_pkg::CMD_WRITE, STRAP, 8'h0e, 8'ha5, 4'h4);
		check("page ack", acked_out, 8'h01);
		repeat (4) @(negedge clk_in);
		check("busy", busy_out, 8'h01);
		run(sepg_pkg::CMD_POLL, STRAP, 8'h00, 8'h00, 4'h0);
		check("busy nack", acked_out, 8'h00);
		poll_wait();
		run(sepg_pkg::CMD_RAND_READ, STRAP, 8'h08, 8'h00, 4'h8);
		for (int i = 0; i < 8; i++) begin
			check("row", rq[i], ROW_EXP[63 - 8 * i -: 8]);
		end
		run(sepg_pkg::CMD_RAND_READ, STRAP, 8'h0d, 8'h00, 4'h1);
		run(sepg_pkg::CMD_CUR_READ, STRAP, 8'h00, 8'h00, 4'h1);
		check("current", rq[0], 8'ha5);
		$display("test page done");
		// top address bit ignored, then read across the last location
		run(sepg_pkg::CMD_WRITE, STRAP, 8'h80, 8'h3c, 4'h1);
		poll_wait();
		@(posedge clk_in);
		page_mode_n <= 1'b1;
		run(sepg_pkg::CMD_RAND_READ, STRAP, 8'h7f, 8'h00, 4'h2);
		check("wrap last", rq[0], sepg_pkg::ERASED_BYTE);
		check("wrap zero", rq[1], 8'h3c);
		$display("test wrap done");
		run(sepg_pkg::CMD_CUR_READ, STRAP ^ 3'h1, 8'h00, 8'h00, 4'h1);
		check("wrong sel ack", acked_out, 8'h00);
		check("wrong sel data", 8'(rq.size()), 8'h00);
		@(posedge clk_in);
		write_protect_input <= 1'b1;
		run(sepg_pkg::CMD_WRITE, STRAP, 8'h20, 8'h11, 4'h1);
		check("protect ack", acked_out, 8'h00);
		@(posedge clk_in);
		write_protect_input <= 1'b0;
		poll_wait();
		run(sepg_pkg::CMD_RAND_READ, STRAP, 8'h20, 8'h00, 4'h1);
		check("protect data", rq[0], sepg_pkg::ERASED_BYTE);
		$display("test select done");
		give_verdict();
	end
endmodule
